// File: ddr_pair_capture.sv
/*
  model of the capturing logic at the far end of one DDR output pair.
  assumes the pair clock and data change together on core edges; the
  capture clock is delayed inside by 1 ns so data is taken just after it changes.
*/
`timescale 1ns/1ps
`default_nettype none

module ddr_pair_capture
(
  input  wire logic        pair_clk,
  input  wire logic [13:1] pair_data,
  input  wire logic        pair_lsb,
  output logic      [13:0] first_word,
  output logic      [13:0] second_word,
  output logic             got
);
  // ----------------------------------------
  // capture
  // ----------------------------------------
  logic clk_dly;

  // delayed clock, as the controller would set up; avoids racing the data edge
  always @(pair_clk) clk_dly <= #1 pair_clk;

  // first channel on the rising edge, second on the falling; one process
  // owns got, which marks a full pair
  always @(posedge clk_dly or negedge clk_dly)
  begin
    if (clk_dly)
    begin
      first_word <= {pair_data, pair_lsb};
      got        <= 1'b0;
    end
    else
    begin
      second_word <= {pair_data, pair_lsb};
      got         <= 1'b1;
    end
  end
endmodule : ddr_pair_capture

`default_nettype wire

// File: quad_adc_defs.svh
/*
  constants for the quad converter output formatter: widths, latencies,
  configuration addresses, field positions and reset values.
  assumes it is included by bare name from the design files.
*/
`ifndef QUAD_ADC_DEFS_SVH
`define QUAD_ADC_DEFS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define CH_NUM            4
`define DATA_W            14
`define RAW_W             16
`define SER_WORD_W        16
`define DLY_DEPTH         27

// ----------------------------------------
// latencies, in output clock cycles, and the last serial bit index
// ----------------------------------------
`define LAT_DEFAULT       5'd10
`define LAT_GAIN          5'd13
`define LAT_GAIN_OFS      5'd14
`define FAST_OVR_DLY      5'd7
`define SER_LAST_BIT      4'hF

// ----------------------------------------
// configuration addresses
// ----------------------------------------
`define ADDR_SOFT_RESET   8'h00
`define ADDR_MODE         8'h01
`define ADDR_DIGITAL      8'h02
`define ADDR_GAIN_BASE    8'h03
`define ADDR_OFFSET       8'h07
`define ADDR_EARLY_THRESH 8'hC3

// ----------------------------------------
// field positions
// ----------------------------------------
`define SOFT_RESET_BIT    1
`define MODE_ALWAYS1_BIT  0
`define MODE_LSB_DIS_BIT  1
`define MODE_FAST_BIT     2
`define DIG_EN_BIT        0
`define DIG_OFS_BIT       1

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define MODE_RESET        3'h4
`define DIG_RESET         2'h0
`define GAIN_RESET        4'h0
`define OFFSET_RESET      8'h00
`define THRESH_RESET      8'hF0
`define POS_FULL          14'h1FFF
`define NEG_FULL          14'h2000

`endif

// File: quad_adc_output_formatter.sv
/*
  back end of a four channel 14-bit converter: sampling, latency, gain,
  overrange and DDR pair multiplexing, plus the serial configuration.
  assumes raw codes come from logic on core_clk, and that core_clk runs
  at twice the sample rate so each output clock edge is one core edge.
*/
`timescale 1ns/1ps
`default_nettype none
`include "quad_adc_defs.svh"

// Notes on behaviour
// - all channels captured together each sample
// - default latency ten output clock cycles
// - gain adds latency: thirteen, fourteen with offset
// - first pair channel leads by half cycle
// - whole channel parallel, first on rising
// - two channels per pair, own clock
// - samples coded as twos complement
// - overrange on bit zero, 13-bit data
// - disable bit gives full 14-bit data
// - normal flag aligned with sample data
// - early flag default, seven cycles delay
// - early threshold held at address C3
// - normal or early selectable any time
// - gain zero to six dB, half steps
// - gain off after reset, enable gives 0dB
// - sixteen bit word, address then data
module quad_adc_output_formatter
  import quad_adc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        serial_select_n,
  input  wire logic        serial_input_line,
  input  wire logic [15:0] raw_sample_a,
  input  wire logic [15:0] raw_sample_b,
  input  wire logic [15:0] raw_sample_c,
  input  wire logic [15:0] raw_sample_d,
  output logic             pair_output_clock_ab_ff,
  output logic             pair_output_clock_cd_ff,
  output logic [13:1]      pair_data_ab_ff,
  output logic [13:1]      pair_data_cd_ff,
  output logic             pair_data_lsb_ab_ff,
  output logic             pair_data_lsb_cd_ff,
  output logic             gain_active_ff
);

  // ----------------------------------------
  // gain table, Q2.12, clamped at 6 dB
  // ----------------------------------------
  function automatic logic [14:0] gain_coef(input gain_code_t code);
    case (code)
      4'h0:    gain_coef = 15'h1000;
      4'h1:    gain_coef = 15'h10F3;
      4'h2:    gain_coef = 15'h11F4;
      4'h3:    gain_coef = 15'h1304;
      4'h4:    gain_coef = 15'h1425;
      4'h5:    gain_coef = 15'h1556;
      4'h6:    gain_coef = 15'h169A;
      4'h7:    gain_coef = 15'h17F1;
      4'h8:    gain_coef = 15'h195C;
      4'h9:    gain_coef = 15'h1ADC;
      4'hA:    gain_coef = 15'h1C74;
      4'hB:    gain_coef = 15'h1E23;
      default: gain_coef = 15'h1FED;
    endcase
  endfunction : gain_coef

  logic              rst_n_s1_ff;
  logic              rst_n_sync_ff;
  logic              tog_s1_ff;
  logic              tog_s2_ff;
  logic              tog_s3_ff;
  logic [2:0]        mode_ff;
  logic [1:0]        dig_ff;
  logic [7:0]        offset_ff;
  logic [7:0]        thresh_ff;
  gain_code_t        gain_ff [`CH_NUM];
  logic              phase_ff;
  logic signed [15:0] samp_ff [`CH_NUM];
  chan_word_t        dly_ff [`CH_NUM][`DLY_DEPTH];
  logic [15:0]       ser_word;
  logic              ser_toggle;
  logic [15:0]       raw_w [`CH_NUM];
  chan_word_t        word_w [`CH_NUM];
  gain_code_t        gain_code_w [`CH_NUM];
  chan_word_t        sel_w [2];
  logic              sel_fast_w [2];
  logic              lsb_w [2];

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      {rst_n_sync_ff, rst_n_s1_ff} <= 2'b00;
    else
      {rst_n_sync_ff, rst_n_s1_ff} <= {rst_n_s1_ff, 1'b1};
  end

  // ----------------------------------------
  // serial configuration and its crossing
  // ----------------------------------------
  serial_word_rx u_rx
  (
    .sclk              (sclk),
    .rst_n             (rst_n_sync_ff),
    .serial_select_n   (serial_select_n),
    .serial_input_line (serial_input_line),
    .word_ff           (ser_word),
    .word_toggle_ff    (ser_toggle)
  );

  // the held word is stable for sixteen shift clocks after the toggle,
  // far longer than the three core cycles the sync takes
  always_ff @(posedge core_clk or negedge rst_n_sync_ff)
  begin
    if (!rst_n_sync_ff)
      {tog_s3_ff, tog_s2_ff, tog_s1_ff} <= 3'h0;
    else
      {tog_s3_ff, tog_s2_ff, tog_s1_ff} <= {tog_s2_ff, tog_s1_ff, ser_toggle};
  end

  // decode of a taken word
  wire       word_take = tog_s2_ff ^ tog_s3_ff;
  wire [7:0] cfg_addr  = ser_word[15:8];
  wire [7:0] cfg_data  = ser_word[7:0];
  wire       wr_soft   = word_take && (cfg_addr == `ADDR_SOFT_RESET)
                         && cfg_data[`SOFT_RESET_BIT];
  wire       wr_mode   = word_take && (cfg_addr == `ADDR_MODE);
  wire       wr_dig    = word_take && (cfg_addr == `ADDR_DIGITAL);
  wire       wr_ofs    = word_take && (cfg_addr == `ADDR_OFFSET);
  wire       wr_thr    = word_take && (cfg_addr == `ADDR_EARLY_THRESH);
  wire       dig_rise  = wr_dig && cfg_data[`DIG_EN_BIT] && !dig_ff[`DIG_EN_BIT];
  wire       dig_en    = dig_ff[`DIG_EN_BIT];
  wire       ofs_en    = dig_ff[`DIG_OFS_BIT];
  wire       lsb_dis   = mode_ff[`MODE_LSB_DIS_BIT];
  wire       fast_sel  = mode_ff[`MODE_FAST_BIT];

  // mode bits; the must-one bit is only stored, the controller owns it
  always_ff @(posedge core_clk or negedge rst_n_sync_ff)
  begin
    if (!rst_n_sync_ff)
      mode_ff <= `MODE_RESET;
    else if (wr_soft)
      mode_ff <= `MODE_RESET;
    else if (wr_mode)
      mode_ff <= cfg_data[2:0];
  end

  // digital enables, offset and early threshold
  always_ff @(posedge core_clk or negedge rst_n_sync_ff)
  begin
    if (!rst_n_sync_ff)
    begin
      dig_ff    <= `DIG_RESET;
      offset_ff <= `OFFSET_RESET;
      thresh_ff <= `THRESH_RESET;
    end
    else if (wr_soft)
    begin
      dig_ff    <= `DIG_RESET;
      offset_ff <= `OFFSET_RESET;
      thresh_ff <= `THRESH_RESET;
    end
    else
    begin
      if (wr_dig)
        dig_ff <= cfg_data[1:0];
      if (wr_ofs)
        offset_ff <= cfg_data;
      if (wr_thr)
        thresh_ff <= cfg_data;
    end
  end

  assign raw_w[0] = raw_sample_a;
  assign raw_w[1] = raw_sample_b;
  assign raw_w[2] = raw_sample_c;
  assign raw_w[3] = raw_sample_d;

  // ----------------------------------------
  // sample phase: one sample per two core edges
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n_sync_ff)
  begin
    if (!rst_n_sync_ff)
      phase_ff <= 1'b0;
    else
      phase_ff <= ~phase_ff;
  end

  // ----------------------------------------
  // per channel: gain, offset, saturation, flags, latency line
  // ----------------------------------------
  for (genvar i = 0; i < `CH_NUM; i++)
  begin : g_ch
    wire signed [30:0] prod;
    wire signed [18:0] scaled;
    wire signed [18:0] ofs_ext;
    wire signed [18:0] corr;
    wire               pos_ovr;
    wire               neg_ovr;
    wire        [15:0] mag;
    wire        [13:0] sat;
    wire               wr_gain = word_take && (cfg_addr == 8'(`ADDR_GAIN_BASE + i));

    // enabling digital functions lands every channel at 0 dB
    always_ff @(posedge core_clk or negedge rst_n_sync_ff)
    begin
      if (!rst_n_sync_ff)
        gain_ff[i] <= `GAIN_RESET;
      else if (wr_soft || dig_rise)
        gain_ff[i] <= `GAIN_RESET;
      else if (wr_gain)
        gain_ff[i] <= cfg_data[3:0];
    end

    // the falling sample edge is the core edge that sees phase high
    always_ff @(posedge core_clk or negedge rst_n_sync_ff)
    begin
      if (!rst_n_sync_ff)
        samp_ff[i] <= 16'h0000;
      else if (phase_ff)
        samp_ff[i] <= raw_w[i];
    end

    // gain is forced to unity while digital functions are off
    assign gain_code_w[i] = dig_en ? gain_ff[i] : `GAIN_RESET;
    assign prod    = samp_ff[i] * $signed({1'b0, gain_coef(gain_code_w[i])});
    assign scaled  = {{2{prod[28]}}, prod[28:12]};
    assign ofs_ext = ofs_en ? {{11{offset_ff[7]}}, offset_ff} : 19'h00000;
    assign corr    = scaled - ofs_ext;
    assign pos_ovr = corr > $signed(19'h01FFF);
    assign neg_ovr = corr < $signed(19'h7E000);
    // saturate to the twos complement full scale codes
    assign sat     = pos_ovr ? `POS_FULL : (neg_ovr ? `NEG_FULL : corr[13:0]);
    // early flag looks at the raw input, before gain and offset
    assign mag     = samp_ff[i][15] ? 16'(-samp_ff[i]) : samp_ff[i];
    assign word_w[i] = {(mag[15:6] >= {2'b00, thresh_ff}), pos_ovr | neg_ovr, sat};

    // per channel lines of equal depth, shifted together, keep all channels of a sample together
    always_ff @(posedge core_clk or negedge rst_n_sync_ff)
    begin
      if (!rst_n_sync_ff)
      begin
        for (int j = 0; j < `DLY_DEPTH; j++)
          dly_ff[i][j] <= 16'h0000;
      end
      else
      begin
        dly_ff[i][0] <= word_w[i];
        for (int j = 1; j < `DLY_DEPTH; j++)
          dly_ff[i][j] <= dly_ff[i][j-1];
      end
    end
  end

  // ----------------------------------------
  // latency taps and pair multiplexing
  // ----------------------------------------
  // taps count core edges: two per output clock cycle
  wire [4:0] lat_sel = !dig_en ? `LAT_DEFAULT
                     : (ofs_en ? `LAT_GAIN_OFS : `LAT_GAIN);
  wire [4:0] tap_b   = 5'(lat_sel * 2 - 2);
  wire [4:0] tap_a   = 5'(tap_b - 5'd1);
  wire [4:0] fast_b  = 5'(`FAST_OVR_DLY * 2 - 2);
  wire [4:0] fast_a  = 5'(fast_b - 5'd1);
  lsb_src_t  lsb_src;

  // mode bits read live, so the flag source can change at any time
  assign lsb_src = lsb_dis ? LSB_DATA
                 : (fast_sel ? LSB_EARLY_OVR : LSB_NORMAL_OVR);

  for (genvar p = 0; p < 2; p++)
  begin : g_pair
    // second channel goes with the falling clock, first with the rising
    assign sel_w[p] = phase_ff ? dly_ff[2*p+1][tap_b] : dly_ff[2*p][tap_a];
    assign sel_fast_w[p] = phase_ff ? dly_ff[2*p+1][fast_b][15]
                                    : dly_ff[2*p][fast_a][15];
    assign lsb_w[p] = (lsb_src == LSB_DATA)       ? sel_w[p][0]
                    : (lsb_src == LSB_EARLY_OVR)  ? sel_fast_w[p]
                    : sel_w[p][14];
  end

  // output flops; the clock copies share one phase source
  always_ff @(posedge core_clk or negedge rst_n_sync_ff)
  begin
    if (!rst_n_sync_ff)
    begin
      pair_output_clock_ab_ff <= 1'b0;
      pair_output_clock_cd_ff <= 1'b0;
      pair_data_ab_ff         <= 13'h0000;
      pair_data_cd_ff         <= 13'h0000;
      pair_data_lsb_ab_ff     <= 1'b0;
      pair_data_lsb_cd_ff     <= 1'b0;
      gain_active_ff          <= 1'b0;
    end
    else
    begin
      pair_output_clock_ab_ff <= ~phase_ff;
      pair_output_clock_cd_ff <= ~phase_ff;
      pair_data_ab_ff         <= sel_w[0][13:1];
      pair_data_cd_ff         <= sel_w[1][13:1];
      pair_data_lsb_ab_ff     <= lsb_w[0];
      pair_data_lsb_cd_ff     <= lsb_w[1];
      gain_active_ff          <= dig_en;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [5:0] quiet_cnt_ff;
  wire        cfg_quiet  = (quiet_cnt_ff == 6'h3F);
  wire [12:0] chk_a_hi   = word_w[0][13:1];
  wire [12:0] chk_b_hi   = word_w[1][13:1];
  wire [12:0] chk_d_hi   = word_w[3][13:1];
  wire        chk_b_ovr  = word_w[1][14];
  wire        chk_b_fast = word_w[1][15];
  wire [13:0] chk_a_data = word_w[0][13:0];
  wire        chk_a_ovr  = word_w[0][14];

  // counts core cycles since the last configuration word
  always_ff @(posedge core_clk or negedge rst_n_sync_ff)
  begin
    if (!rst_n_sync_ff)
      quiet_cnt_ff <= 6'h00;
    else if (word_take)
      quiet_cnt_ff <= 6'h00;
    else if (!cfg_quiet)
      quiet_cnt_ff <= quiet_cnt_ff + 6'h01;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_sync_ff);

  a_sample_together: assert property (phase_ff |=> samp_ff[0] == $past(raw_sample_a)
    && samp_ff[3] == $past(raw_sample_d)) else $error("channels not sampled together");
  a_default_latency: assert property (cfg_quiet && phase_ff && !dig_en
    |=> pair_data_ab_ff == $past(chk_b_hi, 20)) else $error("default latency wrong");
  a_gain_latency: assert property (cfg_quiet && phase_ff && dig_en && !ofs_en
    |=> pair_data_ab_ff == $past(chk_b_hi, 26)) else $error("gain latency wrong");
  a_first_half_early: assert property (cfg_quiet && !phase_ff && !dig_en
    |=> pair_data_ab_ff == $past(chk_a_hi, 19)) else $error("first channel not early");
  a_pair_clock: assert property (1'b1 |=> pair_output_clock_ab_ff != $past(pair_output_clock_ab_ff)
    && pair_output_clock_cd_ff == pair_output_clock_ab_ff) else $error("pair clock wrong");
  a_sat_code: assert property (chk_a_ovr |-> chk_a_data == `POS_FULL
    || chk_a_data == `NEG_FULL) else $error("overrange not saturated");
  a_normal_ovr_lsb: assert property (cfg_quiet && phase_ff && !dig_en && !lsb_dis && !fast_sel
    |=> pair_data_lsb_ab_ff == $past(chk_b_ovr, 20)) else $error("normal flag misaligned");
  a_early_ovr_lsb: assert property (cfg_quiet && phase_ff && !lsb_dis && fast_sel
    |=> pair_data_lsb_ab_ff == $past(chk_b_fast, 14)) else $error("early flag delay wrong");
  a_thresh_write: assert property (wr_thr && !wr_soft
    |=> thresh_ff == $past(cfg_data)) else $error("threshold not stored");
  a_gain_unity_off: assert property (!dig_en |-> gain_code_w[0] == 4'h0
    && gain_code_w[3] == 4'h0) else $error("gain applied while disabled");
  a_enable_zero_db: assert property (dig_rise && !wr_soft
    |=> gain_ff[1] == 4'h0 && dig_en) else $error("enable did not give 0 dB");
  a_quad_aligned: assert property (cfg_quiet && phase_ff && !dig_en
    |=> pair_data_cd_ff == $past(chk_d_hi, 20)) else $error("pairs misaligned");

  c_word_taken: cover property (word_take);
  c_gain_on: cover property (dig_rise);
  c_saturation: cover property (chk_a_ovr);
  c_early_flag: cover property (fast_sel && !lsb_dis && pair_data_lsb_ab_ff);

endmodule : quad_adc_output_formatter
`default_nettype wire

// File: quad_adc_output_formatter_bench.sv
/*
  self-checking bench: random samples, serial configuration, queue of
  expected pair words checked against two capture models.
  assumes the design files and ddr_pair_capture are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "quad_adc_defs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module quad_adc_output_formatter_bench;
  import quad_adc_pkg::*;
  typedef struct {int due; logic [3:0][13:0] w;} note_t;
  // ----------------------------------------
  // signals and state
  // ----------------------------------------
  logic        core_clk, rst_n, sclk, serial_select_n, serial_input_line;
  logic [15:0] raw [4];
  logic        pclk_ab, pclk_cd, l_ab, l_cd, gain_act, got_ab, got_cd;
  logic [13:1] d_ab, d_cd;
  logic [13:0] fa, sb, fc, sd;
  logic [15:0] hist [4096][4];
  int          hcyc [4096];
  int          cyc, num_errors, cmp_count, lat, lsb_sel, thr, ofs, n, i;
  bit          chk, big;
  integer      seed;
  note_t       q [$];

  quad_adc_output_formatter u_quad_adc_output_formatter (.core_clk(core_clk), .rst_n(rst_n),
    .sclk(sclk), .serial_select_n(serial_select_n), .serial_input_line(serial_input_line),
    .raw_sample_a(raw[0]), .raw_sample_b(raw[1]), .raw_sample_c(raw[2]),
    .raw_sample_d(raw[3]), .pair_output_clock_ab_ff(pclk_ab),
    .pair_output_clock_cd_ff(pclk_cd), .pair_data_ab_ff(d_ab), .pair_data_cd_ff(d_cd),
    .pair_data_lsb_ab_ff(l_ab), .pair_data_lsb_cd_ff(l_cd), .gain_active_ff(gain_act));
  ddr_pair_capture cap_ab (.pair_clk(pclk_ab), .pair_data(d_ab), .pair_lsb(l_ab),
    .first_word(fa), .second_word(sb), .got(got_ab));
  ddr_pair_capture cap_cd (.pair_clk(pclk_cd), .pair_data(d_cd), .pair_lsb(l_cd),
    .first_word(fc), .second_word(sd), .got(got_cd));

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) cyc <= cyc + 1;

  // expected line word: saturation, then the chosen use of bit line 0
  function automatic logic [13:0] exp_line(logic [15:0] r, logic [15:0] e);
    int          x;
    int          a;
    logic [13:0] dv;
    logic        overrange_flag;
    x   = int'($signed(r)) - ofs;  // offset is subtracted when enabled
    a   = e[15] ? -int'($signed(e)) : int'($signed(e));
    overrange_flag = (x > 8191) || (x < -8192);
    dv  = x[13:0];
    if (big && r != 16'h0000) overrange_flag = 1'b1;  // doubled large inputs always saturate
    if (overrange_flag) dv = (x < 0) ? `NEG_FULL : `POS_FULL;
    case (lsb_sel)
      0:       exp_line = dv;
      1:       exp_line = {dv[13:1], overrange_flag};
      default: exp_line = {dv[13:1], ((a >> 6) >= thr)};
    endcase
  endfunction : exp_line

  // ----------------------------------------
  // stimulus and expected notes
  // ----------------------------------------
  // capture edges are those after which the pair clock reads low
  initial
  begin : stim
    int          k;
    int          j;
    logic [31:0] v;
    logic [15:0] w;
    seed = 32'h1819;
    for (k = 0; k < 4; k++) raw[k] = 16'h0000;
    forever
    begin
      @(posedge core_clk);
      #1;
      if (chk && pclk_ab === 1'b0)
      begin
        for (k = 0; k < 4; k++) hist[n % 4096][k] = raw[k];
        hcyc[n % 4096] = cyc;
        k = n - (lat - 7);  // early flag belongs to a later sample
        if (k >= 0)
        begin
          q.push_back('{hcyc[k % 4096] + 2 * lat, '0});
          for (j = 0; j < 4; j++) q[$].w[j] = exp_line(hist[k % 4096][j], hist[n % 4096][j]);
        end
        n++;
      end
      for (k = 0; k < 4; k++)
      begin
        v = $random(seed);
        w = 16'd4200 + {4'h0, v[11:0]};
        if (big) raw[k] = v[12] ? 16'h0000 : (v[13] ? -w : w);
        else     raw[k] = v[16] ? v[15:0] : {{3{v[15]}}, v[15:3]};
      end
    end
  end

  // monitor: the oldest note is due when a full pair has been taken
  initial
  begin : mon
    note_t nt;
    forever
    begin
      @(posedge got_ab);
      #0.1;
      if (q.size() > 0 && q[0].due <= cyc)
      begin
        nt = q.pop_front();
        `CHK(nt.due, cyc)
        `CHK(fa, nt.w[0])
        `CHK(sb, nt.w[1])
        `CHK(fc, nt.w[2])
        `CHK(sd, nt.w[3])
        `CHK({got_cd, pclk_cd}, {1'b1, pclk_ab})
      end
    end
  end

  // ----------------------------------------
  // tasks and sequence
  // ----------------------------------------
  // one 16-bit word, address first, MSB first; shift clock runs only in the frame
  task automatic ser_wr(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] wd;
    int          b;
    wd = {a, d};
    @(posedge core_clk);
    #1 serial_select_n = 1'b0;
    #25.3;
    for (b = 15; b >= 0; b--)
    begin
      sclk = 1'b1;
      serial_input_line = wd[b];
      #6 sclk = 1'b0;
      #6;
    end
    #25 serial_select_n = 1'b1;
    serial_input_line = 1'b0;  // released line falls to its pull-down
    repeat (8) @(posedge core_clk);
  endtask : ser_wr

  // skip the mixed-mode window, check a stretch, then let the queue drain
  task automatic run_test(input string name, input logic exp_gain);
    repeat (32) @(posedge core_clk);
    q.delete();
    n = 0;
    chk = 1'b1;
    repeat (120) @(posedge core_clk);
    #1;
    `CHK(gain_act, exp_gain)
    chk = 1'b0;
    repeat (2 * lat + 8) @(posedge core_clk);
    `CHK(q.size(), 0)
    $display("test %s done, mismatches so far %0d", name, num_errors);
  endtask : run_test

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    {rst_n, sclk, serial_input_line, chk, big} = '0;
    serial_select_n = 1'b1;
    {lat, lsb_sel, thr, ofs, num_errors, cmp_count, cyc} = {32'd10, 32'd2, 32'd240, 128'd0};
    repeat (16) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (40) @(posedge core_clk);
    ser_wr(8'hA9, 8'h02);
    ser_wr(8'hAC, 8'h60);
    run_test("reset defaults, early flag", 1'b0);
    ser_wr(`ADDR_MODE, 8'h03);
    lsb_sel = 0;
    run_test("full width data", 1'b0);
    ser_wr(`ADDR_MODE, 8'h01);
    lsb_sel = 1;
    run_test("normal overrange", 1'b0);
    ser_wr(`ADDR_EARLY_THRESH, 8'h80);
    ser_wr(`ADDR_MODE, 8'h05);
    ser_wr(8'h7F, 8'hFF);  // unmapped, must change nothing
    {lsb_sel, thr} = {32'd2, 32'd128};
    run_test("early threshold", 1'b0);
    ser_wr(`ADDR_DIGITAL, 8'h01);
    ser_wr(`ADDR_MODE, 8'h01);
    {lsb_sel, lat} = {32'd1, 32'd13};
    run_test("gain at 0 dB", 1'b1);
    ser_wr(`ADDR_OFFSET, 8'h10);
    ser_wr(`ADDR_DIGITAL, 8'h03);
    {lat, ofs} = {32'd14, 32'd16};
    run_test("gain and offset", 1'b1);
    for (i = 0; i < 4; i++) ser_wr(`ADDR_GAIN_BASE + 8'(i), 8'h0C);
    big = 1'b1;
    run_test("6 dB gain", 1'b1);
    ser_wr(`ADDR_SOFT_RESET, 8'h02);
    ser_wr(`ADDR_MODE, 8'h05);
    {big, lat, lsb_sel, thr, ofs} = {1'b0, 32'd10, 32'd2, 32'd240, 32'd0};
    run_test("software reset", 1'b0);
    print_verdict();
  end
endmodule : quad_adc_output_formatter_bench

`default_nettype wire

// File: quad_adc_pkg.sv
/*
  shared types of the quad converter output formatter.
  assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package quad_adc_pkg;
  typedef logic [15:0] chan_word_t;   // {early flag, overrange, data[13:0]}
  typedef logic [3:0]  gain_code_t;   // half-dB steps
  typedef enum {LSB_DATA, LSB_NORMAL_OVR, LSB_EARLY_OVR} lsb_src_t;
endpackage : quad_adc_pkg
`default_nettype wire

// File: serial_word_rx.sv
/*
  serial configuration word receiver, running on the shift clock.
  assumes the shift clock only moves while the select line is low and
  that rst_n is already synchronous to the core clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "quad_adc_defs.svh"

module serial_word_rx
(
  input  wire logic        sclk,
  input  wire logic        rst_n,
  input  wire logic        serial_select_n,
  input  wire logic        serial_input_line,
  output logic [15:0]      word_ff,
  output logic             word_toggle_ff
);

  logic [3:0]  bit_cnt_ff;
  logic [14:0] shift_ff;
  wire         frame_clr_n = rst_n & ~serial_select_n;
  wire         last_bit    = (bit_cnt_ff == `SER_LAST_BIT);

  // ----------------------------------------
  // shifter, cleared by the frame's own select
  // ----------------------------------------
  // the shift clock stands still between frames, so the select line ends
  // the frame rather than any edge that may never come
  always_ff @(negedge sclk or negedge frame_clr_n)
  begin
    if (!frame_clr_n)
    begin
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 15'h0000;
    end
    else
    begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
      shift_ff   <= {shift_ff[13:0], serial_input_line};
    end
  end

  // ----------------------------------------
  // word hand-off: held word plus toggle
  // ----------------------------------------
  // excess bits past a 16-bit multiple never reach the toggle
  always_ff @(negedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word_ff        <= 16'h0000;
      word_toggle_ff <= 1'b0;
    end
    else if (!serial_select_n && last_bit)
    begin
      word_ff        <= {shift_ff, serial_input_line};
      word_toggle_ff <= ~word_toggle_ff;
    end
  end

endmodule : serial_word_rx
`default_nettype wire
